// ### src/pixfmt_pkg.sv
package pixfmt_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  // register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_ROP = 8'h04;
  localparam logic [7:0] ADDR_WMASK = 8'h08;
  localparam logic [7:0] ADDR_FG = 8'h0c;
  localparam logic [7:0] ADDR_BG = 8'h10;
  localparam logic [7:0] ADDR_BLK = 8'h14;
  localparam logic [7:0] ADDR_DEEP = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1c;
  // field positions
  localparam int MODE_LO = 0;
  localparam int MODE_HI = 3;
  localparam int SRC_BM_LO = 8;
  localparam int SRC_BM_HI = 10;
  localparam int SRC_BY_LO = 11;
  localparam int SRC_BY_HI = 12;
  localparam int ZFMT_BIT = 14;
  localparam int DST_BM_LO = 8;
  localparam int DST_BM_HI = 9;
  localparam int DST_BY_LO = 10;
  localparam int DST_BY_HI = 11;
  localparam int STAT_FMT_BIT = 0;
  localparam int STAT_DEPTH_BIT = 1;
  // reset values
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] ROP_RST = 32'h0000_0000;
  localparam logic [31:0] WMASK_RST = 32'hffff_ffff;
  localparam logic [31:0] COLOUR_RST = 32'h0000_0000;
  // source bitmap codes
  localparam logic [2:0] SRC_PACKED = 3'h0;
  localparam logic [2:0] SRC_UNPACKED = 3'h1;
  localparam logic [2:0] SRC_NIB0 = 3'h2;
  localparam logic [2:0] SRC_TRUE = 3'h3;
  localparam logic [2:0] SRC_NIB1 = 3'h4;
  // destination bitmap codes
  localparam logic [1:0] DST_PACKED = 2'h0;
  localparam logic [1:0] DST_UNPACKED = 2'h1;
  localparam logic [1:0] DST_NIB = 2'h2;
  localparam logic [1:0] DST_TRUE = 2'h3;
  typedef enum logic [3:0] {
    M_SIMPLE, M_SIMPLE_Z, M_OPQ_STIP, M_OPQ_LINE, M_TRN_STIP, M_TRN_LINE,
    M_BLK_STIP, M_BLK_FILL, M_INTERP, M_INTERP_Z, M_COPY, M_DMA_RD, M_DMA_WR
  } mode_type;
endpackage

// ### src/operand_extract.sv
module operand_extract (
  // frame-buffer source dword
  input wire logic [31:0] src_word,
  // format select
  input wire logic [2:0] src_bm,
  input wire logic [1:0] src_byte,
  // internal operand
  output logic [31:0] operand
);
  logic [7:0] sel_byte;
  logic [3:0] red;
  logic [3:0] green;
  logic [3:0] blue;

  // byte code 3 reaches the tag byte
  assign sel_byte = src_word[8*src_byte +: 8];

  always_comb begin
    red = src_word[19:16];
    green = src_word[11:8];
    blue = src_word[3:0];
    if (src_bm == pixfmt_pkg::SRC_NIB1) begin
      red = src_word[23:20];
      green = src_word[15:12];
      blue = src_word[7:4];
    end
  end

  always_comb begin
    unique case (src_bm)
      // one pixel per dword: unpacked pixel lands in the low byte
      pixfmt_pkg::SRC_UNPACKED: operand = {24'h00_0000, sel_byte};
      // duplicated into both nibble layouts; plane mask picks one
      pixfmt_pkg::SRC_NIB0, pixfmt_pkg::SRC_NIB1:
        operand = {src_word[31:24], red, red, green, green, blue, blue};
      default: operand = src_word;
    endcase
  end
endmodule

// ### src/dest_merge.sv
module dest_merge (
  // operand and current dword
  input wire logic [31:0] new_op,
  input wire logic [31:0] old_word,
  input wire logic [31:0] plane_mask,
  // format select
  input wire logic [1:0] dst_bm,
  input wire logic [1:0] dst_byte,
  // merged dword
  output logic [31:0] merged
);
  logic [3:0] lane;
  logic [31:0] placed;

  always_comb begin
    lane = 4'hf;
    placed = new_op;
    if (dst_bm == pixfmt_pkg::DST_UNPACKED) begin
      lane = 4'h1 << dst_byte;
      placed = {4{new_op[7:0]}};
    end
  end

  // untouched lanes keep the co-resident bitmaps intact
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_lane
      logic [7:0] en;
      assign en = plane_mask[8*i +: 8] & {8{lane[i]}};
      assign merged[8*i +: 8] = (old_word[8*i +: 8] & ~en) | (placed[8*i +: 8] & en);
    end
  endgenerate
endmodule

// ### src/pixel_operand_format_select.sv
module pixel_operand_format_select (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pixfmt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // operation request
  input wire logic op_valid,
  input wire logic stip_fg,
  input wire logic [31:0] pci_data,
  input wire logic [31:0] interp_data,
  input wire logic [31:0] fb_src_data,
  input wire logic [31:0] fb_dst_old,
  input wire logic [23:0] z_new,
  input wire logic [7:0] stencil_new,
  // frame buffer write
  output logic fb_wr_valid,
  output logic [31:0] fb_wr_data,
  // depth/stencil write
  output logic z_wr_valid,
  output logic [31:0] z_wr_data,
  // pci memory write
  output logic pci_wr_valid,
  output logic [31:0] pci_wr_data,
  // format or depth fault pulse
  output logic op_fault
);
  logic [31:0] mode_control_reg_r;
  logic [31:0] raster_operation_reg_r;
  logic [31:0] write_bit_mask_reg_r;
  logic [31:0] foreground_colour_reg_r;
  logic [31:0] background_colour_reg_r;
  logic [31:0] block_colour_reg_r;
  logic deep_r;
  logic fmt_err_r;
  logic depth_err_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic fb_wr_valid_r;
  logic [31:0] fb_wr_data_r;
  logic z_wr_valid_r;
  logic [31:0] z_wr_data_r;
  logic pci_wr_valid_r;
  logic [31:0] pci_wr_data_r;
  logic op_fault_r;

  logic acc;
  logic wr_en;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] stat_word;
  pixfmt_pkg::mode_type mode;
  logic [2:0] src_bm;
  logic [1:0] src_byte;
  logic [1:0] dst_bm;
  logic [1:0] dst_byte;
  logic z_shallow;
  logic [31:0] fb_operand;
  logic [31:0] src_op;
  logic [31:0] merged;
  logic is_depth;
  logic fmt_bad;
  logic depth_bad;
  logic [1:0] src_cls;
  logic [1:0] dst_cls;

  assign mode = pixfmt_pkg::mode_type'(mode_control_reg_r[pixfmt_pkg::MODE_HI:pixfmt_pkg::MODE_LO]);
  assign src_bm = mode_control_reg_r[pixfmt_pkg::SRC_BM_HI:pixfmt_pkg::SRC_BM_LO];
  assign src_byte = mode_control_reg_r[pixfmt_pkg::SRC_BY_HI:pixfmt_pkg::SRC_BY_LO];
  assign dst_bm = raster_operation_reg_r[pixfmt_pkg::DST_BM_HI:pixfmt_pkg::DST_BM_LO];
  assign dst_byte = raster_operation_reg_r[pixfmt_pkg::DST_BY_HI:pixfmt_pkg::DST_BY_LO];
  assign z_shallow = mode_control_reg_r[pixfmt_pkg::ZFMT_BIT];

  // apb: one wait state so read data comes from a flop
  assign acc = psel & penable;
  assign wr_en = acc & pwrite & pready_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  assign stat_word = {30'h0000_0000, depth_err_r, fmt_err_r};

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      pixfmt_pkg::ADDR_MODE: rd_mux = mode_control_reg_r;
      pixfmt_pkg::ADDR_ROP: rd_mux = raster_operation_reg_r;
      pixfmt_pkg::ADDR_WMASK: rd_mux = write_bit_mask_reg_r;
      pixfmt_pkg::ADDR_FG: rd_mux = foreground_colour_reg_r;
      pixfmt_pkg::ADDR_BG: rd_mux = background_colour_reg_r;
      pixfmt_pkg::ADDR_BLK: rd_mux = block_colour_reg_r;
      pixfmt_pkg::ADDR_DEEP: rd_mux = {31'h0000_0000, deep_r};
      pixfmt_pkg::ADDR_STAT: rd_mux = stat_word;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= acc & ~pready_r;
      pslverr_r <= acc & ~pready_r & ~mapped;
      prdata_r <= (acc & ~pready_r & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_control_reg_r <= pixfmt_pkg::MODE_RST;
      raster_operation_reg_r <= pixfmt_pkg::ROP_RST;
      write_bit_mask_reg_r <= pixfmt_pkg::WMASK_RST;
      foreground_colour_reg_r <= pixfmt_pkg::COLOUR_RST;
      background_colour_reg_r <= pixfmt_pkg::COLOUR_RST;
      block_colour_reg_r <= pixfmt_pkg::COLOUR_RST;
      deep_r <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        pixfmt_pkg::ADDR_MODE: mode_control_reg_r <= pwdata;
        pixfmt_pkg::ADDR_ROP: raster_operation_reg_r <= pwdata;
        pixfmt_pkg::ADDR_WMASK: write_bit_mask_reg_r <= pwdata;
        pixfmt_pkg::ADDR_FG: foreground_colour_reg_r <= pwdata;
        pixfmt_pkg::ADDR_BG: background_colour_reg_r <= pwdata;
        pixfmt_pkg::ADDR_BLK: block_colour_reg_r <= pwdata;
        pixfmt_pkg::ADDR_DEEP: deep_r <= pwdata[0];
        default: ;
      endcase
    end
  end

  // sticky faults; a new fault beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_err_r <= 1'b0;
      depth_err_r <= 1'b0;
    end else begin
      if (op_valid & fmt_bad)
        fmt_err_r <= 1'b1;
      else if (wr_en && paddr == pixfmt_pkg::ADDR_STAT && pwdata[pixfmt_pkg::STAT_FMT_BIT])
        fmt_err_r <= 1'b0;
      if (op_valid & depth_bad)
        depth_err_r <= 1'b1;
      else if (wr_en && paddr == pixfmt_pkg::ADDR_STAT && pwdata[pixfmt_pkg::STAT_DEPTH_BIT])
        depth_err_r <= 1'b0;
    end
  end

  operand_extract u_extract (
    .src_word(fb_src_data),
    .src_bm(src_bm),
    .src_byte(src_byte),
    .operand(fb_operand)
  );

  // source origin per mode
  always_comb begin
    unique case (mode)
      pixfmt_pkg::M_OPQ_STIP, pixfmt_pkg::M_OPQ_LINE,
      pixfmt_pkg::M_TRN_STIP, pixfmt_pkg::M_TRN_LINE:
        src_op = stip_fg ? foreground_colour_reg_r : background_colour_reg_r;
      pixfmt_pkg::M_BLK_STIP, pixfmt_pkg::M_BLK_FILL:
        src_op = {4{block_colour_reg_r[7:0]}};
      pixfmt_pkg::M_INTERP, pixfmt_pkg::M_INTERP_Z: src_op = interp_data;
      // byte fields only apply where the frame buffer is the source
      pixfmt_pkg::M_COPY, pixfmt_pkg::M_DMA_WR: src_op = fb_operand;
      default: src_op = pci_data;
    endcase
  end

  dest_merge u_merge (
    .new_op(src_op),
    .old_word(fb_dst_old),
    .plane_mask(write_bit_mask_reg_r),
    .dst_bm(dst_bm),
    .dst_byte(dst_byte),
    .merged(merged)
  );

  // depth-class of each operand: 0 bytes, 1 nibbles, 2 true colour
  always_comb begin
    src_cls = 2'h0;
    if (src_bm == pixfmt_pkg::SRC_NIB0 || src_bm == pixfmt_pkg::SRC_NIB1)
      src_cls = 2'h1;
    else if (src_bm == pixfmt_pkg::SRC_TRUE)
      src_cls = 2'h2;
    dst_cls = 2'h0;
    if (dst_bm == pixfmt_pkg::DST_NIB)
      dst_cls = 2'h1;
    else if (dst_bm == pixfmt_pkg::DST_TRUE)
      dst_cls = 2'h2;
  end

  assign is_depth = (mode == pixfmt_pkg::M_SIMPLE_Z) || (mode == pixfmt_pkg::M_INTERP_Z);
  // only a 32-bpp frame buffer carries depth; shallow needs the unpacked bitmap at byte 0
  assign depth_bad = is_depth & (~deep_r | (z_shallow & (dst_bm != pixfmt_pkg::DST_UNPACKED
                     || dst_byte != 2'h0)));
  // format faults are flagged, the operation still runs
  assign fmt_bad =
      ((mode == pixfmt_pkg::M_COPY || mode == pixfmt_pkg::M_DMA_RD || mode == pixfmt_pkg::M_DMA_WR)
       && src_cls != dst_cls)
    | (mode == pixfmt_pkg::M_DMA_WR && dst_bm == pixfmt_pkg::DST_UNPACKED)
    | (mode == pixfmt_pkg::M_DMA_RD && src_bm == pixfmt_pkg::SRC_UNPACKED)
    | ((mode == pixfmt_pkg::M_BLK_STIP || mode == pixfmt_pkg::M_BLK_FILL) && deep_r
       && dst_bm == pixfmt_pkg::DST_PACKED);

  // results register one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_wr_valid_r <= 1'b0;
      fb_wr_data_r <= 32'h0000_0000;
      pci_wr_valid_r <= 1'b0;
      pci_wr_data_r <= 32'h0000_0000;
      op_fault_r <= 1'b0;
    end else begin
      fb_wr_valid_r <= op_valid && mode != pixfmt_pkg::M_DMA_WR
                       && !(is_depth && z_shallow);
      fb_wr_data_r <= merged;
      pci_wr_valid_r <= op_valid && mode == pixfmt_pkg::M_DMA_WR;
      pci_wr_data_r <= src_op;
      op_fault_r <= op_valid & (fmt_bad | depth_bad);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      z_wr_valid_r <= 1'b0;
      z_wr_data_r <= 32'h0000_0000;
    end else begin
      z_wr_valid_r <= op_valid & is_depth & deep_r;
      if (z_shallow)
        z_wr_data_r <= {stencil_new, z_new[15:0], merged[7:0]};
      else
        z_wr_data_r <= {stencil_new, z_new};
    end
  end

  assign fb_wr_valid = fb_wr_valid_r;
  assign fb_wr_data = fb_wr_data_r;
  assign z_wr_valid = z_wr_valid_r;
  assign z_wr_data = z_wr_data_r;
  assign pci_wr_valid = pci_wr_valid_r;
  assign pci_wr_data = pci_wr_data_r;
  assign op_fault = op_fault_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_mask_keeps;
    fb_wr_valid_r |-> ((fb_wr_data_r ^ $past(fb_dst_old)) & ~$past(write_bit_mask_reg_r)) == 0;
  endproperty
  a_mask_keeps: assert property (p_mask_keeps) else $error("masked bits changed");

  property p_depth_deep;
    z_wr_valid_r |-> $past(deep_r) && $past(op_valid);
  endproperty
  a_depth_deep: assert property (p_depth_deep) else $error("depth write without deep");

  property p_shallow_no_fb;
    op_valid && is_depth && z_shallow |=> !fb_wr_valid_r;
  endproperty
  a_shallow_no_fb: assert property (p_shallow_no_fb) else $error("shallow wrote pixel");

  property p_deep_pack;
    op_valid && is_depth && deep_r && !z_shallow |=>
      z_wr_valid_r && z_wr_data_r == {$past(stencil_new), $past(z_new)} && fb_wr_valid_r;
  endproperty
  a_deep_pack: assert property (p_deep_pack) else $error("deep layout wrong");

  property p_dma_wr;
    op_valid && mode == pixfmt_pkg::M_DMA_WR |=> pci_wr_valid_r && !fb_wr_valid_r;
  endproperty
  a_dma_wr: assert property (p_dma_wr) else $error("dma write path wrong");

  property p_simple_src;
    op_valid && mode == pixfmt_pkg::M_SIMPLE && write_bit_mask_reg_r == 32'hffff_ffff
      && dst_bm == pixfmt_pkg::DST_TRUE |=> fb_wr_data_r == $past(pci_data);
  endproperty
  a_simple_src: assert property (p_simple_src) else $error("simple source wrong");

  property p_lane0;
    op_valid && !is_depth && dst_bm == pixfmt_pkg::DST_UNPACKED && dst_byte == 2'h0
      |=> fb_wr_data_r[31:8] == $past(fb_dst_old[31:8]);
  endproperty
  a_lane0: assert property (p_lane0) else $error("other bitmaps corrupted");

  property p_zfmt_bit;
    wr_en && paddr == pixfmt_pkg::ADDR_MODE |=> z_shallow == $past(pwdata[14]);
  endproperty
  a_zfmt_bit: assert property (p_zfmt_bit) else $error("depth layout bit wrong");
endmodule

// ### tb/fb_pci_mem.sv
module fb_pci_mem (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // preload from the bench
  input wire logic ld,
  input wire logic [31:0] ld_dst,
  input wire logic [31:0] ld_src,
  // writes from the block
  input wire logic fb_wr_valid,
  input wire logic [31:0] fb_wr_data,
  input wire logic pci_wr_valid,
  input wire logic [31:0] pci_wr_data,
  // read data to the block
  output logic [31:0] fb_dst_old,
  output logic [31:0] fb_src_data,
  output logic [31:0] pci_store
);
  timeunit 1ns;
  timeprecision 1ps;
  // whole dword lands: only the block's own masking protects neighbours
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_dst_old <= 32'h0;
      fb_src_data <= 32'h0;
      pci_store <= 32'h0;
    end else begin
      if (ld) begin
        fb_dst_old <= ld_dst;
        fb_src_data <= ld_src;
      end else if (fb_wr_valid) begin
        fb_dst_old <= fb_wr_data;
      end
      if (pci_wr_valid) begin
        pci_store <= pci_wr_data;
      end
    end
  end
endmodule

// ### tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, op_valid = 1'h0, stip_fg = 1'h0, ld = 1'h0;
  logic [7:0] paddr = 8'h0, stencil_new = 8'h9a;
  logic [23:0] z_new = 24'hababab;
  logic [31:0] pwdata = 32'h0, pci_data = 32'h0, interp_data = 32'h00c0ffee;
  logic [31:0] ld_dst = 32'h0, ld_src = 32'h0, rdv;
  logic [31:0] prdata, fb_wr_data, z_wr_data, pci_wr_data, fb_src_data, fb_dst_old, pci_store;
  logic pready, pslverr, fb_wr_valid, z_wr_valid, pci_wr_valid, op_fault, errv;
  int num_errors = 0, total_checks = 0, cycles = 0;

  pixel_operand_format_select pixel_operand_format_select_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .op_valid, .stip_fg, .pci_data,
    .interp_data, .fb_src_data, .fb_dst_old, .z_new, .stencil_new, .fb_wr_valid, .fb_wr_data,
    .z_wr_valid, .z_wr_data, .pci_wr_valid, .pci_wr_data, .op_fault);
  fb_pci_mem fb_pci_mem_i (.pclk, .presetn, .ld, .ld_dst, .ld_src, .fb_wr_valid, .fb_wr_data,
    .pci_wr_valid, .pci_wr_data, .fb_dst_old, .fb_src_data, .pci_store);

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a few hundred cycles are needed; the ceiling leaves ample margin
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic chk_w(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask

  task automatic chk_b(input logic got, input logic want);
    total_checks++;
    if (got !== want) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask

  // apb master: request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // no local limit: only the bench watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want, input logic err);
    apb(1'h0, a, 32'h0);
    chk_w(rdv, want);
    chk_b(errv, err);
  endtask

  task automatic setup(input pixfmt_pkg::mode_type m, input logic [2:0] sbm,
      input logic [1:0] sby, input logic z, input logic [1:0] dbm, input logic [1:0] dby,
      input logic [31:0] k);
    apb(1'h1, pixfmt_pkg::ADDR_MODE, {17'h0, z, 1'h0, sby, sbm, 4'h0, m});
    apb(1'h1, pixfmt_pkg::ADDR_ROP, {20'h0, dby, dbm, 8'h0});
    apb(1'h1, pixfmt_pkg::ADDR_WMASK, k);
  endtask

  // preload memory, then one operation; results sampled in the pulse cycle
  task automatic op(input logic rl, input logic [31:0] dst, input logic [31:0] src,
      input logic [31:0] pci);
    @(posedge pclk);
    ld <= rl;
    ld_dst <= dst;
    ld_src <= src;
    pci_data <= pci;
    @(posedge pclk);
    ld <= 1'h0;
    op_valid <= 1'h1;
    @(posedge pclk);
    op_valid <= 1'h0;
    #1;
  endtask

  task automatic chk_fb(input logic [31:0] want);
    chk_b(fb_wr_valid, 1'h1);
    chk_w(fb_wr_data, want);
    chk_b(op_fault, 1'h0);
  endtask

  function automatic logic [31:0] put_lane(logic [31:0] w, int k, logic [7:0] b);
    w[k*8 +: 8] = b;
    return w;
  endfunction

  initial begin
    static pixfmt_pkg::mode_type ml[9] = '{pixfmt_pkg::M_OPQ_STIP, pixfmt_pkg::M_OPQ_LINE,
      pixfmt_pkg::M_BLK_FILL, pixfmt_pkg::M_INTERP, pixfmt_pkg::M_DMA_RD,
      pixfmt_pkg::M_TRN_STIP, pixfmt_pkg::M_TRN_LINE, pixfmt_pkg::M_BLK_STIP,
      pixfmt_pkg::M_INTERP_Z};
    static logic [31:0] el[9] = '{32'h00aa55cc, 32'h00112233, 32'h3c3c3c3c, 32'h00c0ffee,
      32'h0bad0f0d, 32'h00aa55cc, 32'h00112233, 32'h3c3c3c3c, 32'h00c0ffee};
    static pixfmt_pkg::mode_type fm[3] = '{pixfmt_pkg::M_COPY, pixfmt_pkg::M_DMA_RD,
      pixfmt_pkg::M_BLK_FILL};
    static logic [2:0] fs[3] = '{3'h1, 3'h1, 3'h0};
    static logic [1:0] fd[3] = '{2'h3, 2'h0, 2'h0};
    static logic [31:0] sw = 32'h44332211;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rd_chk(pixfmt_pkg::ADDR_MODE, pixfmt_pkg::MODE_RST, 1'h0);
    rd_chk(pixfmt_pkg::ADDR_WMASK, pixfmt_pkg::WMASK_RST, 1'h0);
    rd_chk(8'h20, 32'h0, 1'h1);
    apb(1'h1, pixfmt_pkg::ADDR_DEEP, 32'h1);
    apb(1'h1, pixfmt_pkg::ADDR_FG, 32'h00aa55cc);
    apb(1'h1, pixfmt_pkg::ADDR_BG, 32'h00112233);
    apb(1'h1, pixfmt_pkg::ADDR_BLK, 32'h0000003c);
    setup(pixfmt_pkg::M_SIMPLE, 3'h3, 2'h0, 1'h0, 2'h3, 2'h0, 32'hffffffff);
    op(1'h1, 32'h0, 32'h0, 32'h5a112233);
    chk_fb(32'h5a112233);
    // two nibble bitmaps written in turn into one dword
    setup(pixfmt_pkg::M_SIMPLE, pixfmt_pkg::SRC_NIB0, 2'h0, 1'h0, pixfmt_pkg::DST_NIB, 2'h0,
      32'h000f0f0f);
    op(1'h1, 32'haabbccdd, 32'h0, 32'h12334455);
    chk_fb(32'haab3c4d5);
    apb(1'h1, pixfmt_pkg::ADDR_WMASK, 32'h00f0f0f0);
    op(1'h0, 32'h0, 32'h0, 32'h66778899);
    chk_fb(32'haa738495);
    for (int i = 0; i < 2; i++) begin
      setup(pixfmt_pkg::M_COPY, i ? pixfmt_pkg::SRC_NIB1 : pixfmt_pkg::SRC_NIB0, 2'h0, 1'h0,
        pixfmt_pkg::DST_NIB, 2'h0, 32'h00f0f0f0);
      op(1'h1, 32'h11223344, i ? 32'h00a0b0c0 : 32'h000a0b0c, 32'h0);
      chk_fb(32'h11a2b3c4);
    end
    for (int k = 0; k < 4; k++) begin
      setup(pixfmt_pkg::M_SIMPLE, 3'h1, 2'h0, 1'h0, 2'h1, 2'(k), 32'hffffffff);
      op(1'h1, 32'haabbccdd, 32'h0, 32'h77777777);
      chk_fb(put_lane(32'haabbccdd, k, 8'h77));
      setup(pixfmt_pkg::M_COPY, 3'h1, 2'(k), 1'h0, 2'h1, 2'(3 - k), 32'hffffffff);
      op(1'h1, 32'haabbccdd, sw, 32'h0);
      chk_fb(put_lane(32'haabbccdd, 3 - k, sw[k*8 +: 8]));
    end
    // stipple, line, block, interpolated and dma-read modes once; block modes target true colour, not packed bytes
    for (int i = 0; i < 9; i++) begin
      setup(ml[i], 3'h3, 2'h0, 1'h0, 2'h3, 2'h0, 32'hffffffff);
      stip_fg <= (i == 0 || i == 5);
      op(1'h1, 32'h0, 32'h0, 32'h0bad0f0d);
      chk_fb(el[i]);
    end
    setup(pixfmt_pkg::M_DMA_WR, 3'h3, 2'h0, 1'h0, 2'h3, 2'h0, 32'hffffffff);
    op(1'h1, 32'h0, 32'h5e6f7a8b, 32'h0);
    chk_b(fb_wr_valid, 1'h0);
    chk_b(pci_wr_valid, 1'h1);
    chk_w(pci_wr_data, 32'h5e6f7a8b);
    @(posedge pclk);
    #1;
    chk_w(pci_store, 32'h5e6f7a8b);
    // faults only flag; the op still runs
    for (int i = 0; i < 3; i++) begin
      setup(fm[i], fs[i], 2'h0, 1'h0, fd[i], 2'h0, 32'hffffffff);
      op(1'h1, 32'h0, 32'h0, 32'h0);
      chk_b(op_fault, 1'h1);
    end
    rd_chk(pixfmt_pkg::ADDR_STAT, 32'h1, 1'h0);
    apb(1'h1, pixfmt_pkg::ADDR_STAT, 32'h1);
    rd_chk(pixfmt_pkg::ADDR_STAT, 32'h0, 1'h0);
    setup(pixfmt_pkg::M_SIMPLE_Z, 3'h3, 2'h0, 1'h0, 2'h3, 2'h0, 32'hffffffff);
    op(1'h1, 32'h0, 32'h0, 32'h00fedcba);
    chk_b(z_wr_valid, 1'h1);
    chk_w(z_wr_data, 32'h9aababab);
    chk_fb(32'h00fedcba);
    // shallow layout: pixel rides in the depth dword
    setup(pixfmt_pkg::M_SIMPLE_Z, 3'h1, 2'h0, 1'h1, 2'h1, 2'h0, 32'hffffffff);
    op(1'h1, 32'h0, 32'h0, 32'heeeeeeee);
    chk_w(z_wr_data, 32'h9aababee);
    chk_b(fb_wr_valid, 1'h0);
    apb(1'h1, pixfmt_pkg::ADDR_DEEP, 32'h0);
    op(1'h1, 32'h0, 32'h0, 32'h0);
    chk_b(z_wr_valid, 1'h0);
    rd_chk(pixfmt_pkg::ADDR_STAT, 32'h2, 1'h0);
    complete_run();
  end
endmodule
